/* verilog/serial_latched_driver.sv */
// logic of an eight-channel serial-input latched sink driver
// assumes the link pins arrive asynchronously to clk_i and are resynchronised here; rst_n_i is used as it arrives
`timescale 1ns/100ps
`include "latched_driver_map.svh"
module serial_latched_driver import latched_driver_pkg::*; #(
   parameter int CHANNELS = `LD_CHANNELS
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // serial link pins
   input wire logic shift_clk_i,
   input wire logic serial_in_i,
   input wire logic strobe_i,
   input wire logic out_disable_i,
   output logic serial_out_o,
   // driver controls, one means sink on
   output logic [CHANNELS-1:0] sink_on_o
);

   // ********************************
   // pin synchronisers
   // ********************************
   // data passes the same depth as the clock so its level matches at the edge
   // limitation: pin pulses shorter than about two clocks may be missed,
   // and nothing flags the loss to the controller
   sync_vec_t sclk_sync_reg;
   sync_vec_t sdat_sync_reg;
   sync_vec_t strb_sync_reg;
   sync_vec_t oe_sync_reg;
   logic sclk_level_reg;
   logic strb_level_reg;
   logic oe_level_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sclk_sync_reg <= '0;
         sdat_sync_reg <= '0;
         strb_sync_reg <= '0;
         oe_sync_reg <= '1;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[`LD_SYNC_LAST-1:0], shift_clk_i};
         sdat_sync_reg <= {sdat_sync_reg[`LD_SYNC_LAST-1:0], serial_in_i};
         strb_sync_reg <= {strb_sync_reg[`LD_SYNC_LAST-1:0], strobe_i};
         oe_sync_reg <= {oe_sync_reg[`LD_SYNC_LAST-1:0], out_disable_i};
      end
   end

   // a change counts only once stages two and three agree
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sclk_level_reg <= 1'b0;
         strb_level_reg <= 1'b0;
         oe_level_reg <= 1'b1;
      end else begin
         if (sclk_sync_reg[`LD_SYNC_MID] == sclk_sync_reg[`LD_SYNC_LAST]) begin
            sclk_level_reg <= sclk_sync_reg[`LD_SYNC_LAST];
         end
         if (strb_sync_reg[`LD_SYNC_MID] == strb_sync_reg[`LD_SYNC_LAST]) begin
            strb_level_reg <= strb_sync_reg[`LD_SYNC_LAST];
         end
         if (oe_sync_reg[`LD_SYNC_MID] == oe_sync_reg[`LD_SYNC_LAST]) begin
            oe_level_reg <= oe_sync_reg[`LD_SYNC_LAST];
         end
      end
   end

   logic sclk_rise;
   // level register starts low like the idle pin, so reset gives no false edge
   assign sclk_rise = (sclk_sync_reg[`LD_SYNC_MID] == sclk_sync_reg[`LD_SYNC_LAST]) &&
      sclk_sync_reg[`LD_SYNC_LAST] && !sclk_level_reg;

   // ********************************
   // shift register
   // ********************************
   logic [CHANNELS-1:0] shift_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         shift_reg <= '0;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[CHANNELS-2:0], sdat_sync_reg[`LD_SYNC_LAST]};
      end
   end

   assign serial_out_o = shift_reg[CHANNELS-1];

   // ********************************
   // latches and drivers
   // ********************************
   logic [CHANNELS-1:0] latch_reg;
   logic [CHANNELS-1:0] sink_reg;

   // transparent while strobe high, so shifting shows through
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         latch_reg <= '0;
      end else if (strb_level_reg) begin
         latch_reg <= shift_reg;
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < CHANNELS; ch++) begin : g_drv
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               sink_reg[ch] <= 1'b0;
            end else begin
               sink_reg[ch] <= latch_reg[ch] && !oe_level_reg;
            end
         end
      end
   endgenerate

   assign sink_on_o = sink_reg;

   // ********************************
   // assertions
   // ********************************
   sequence s_strobe_open;
      strb_level_reg;
   endsequence

   sequence s_edge_seen;
      sclk_rise;
   endsequence

   sequence s_drive_enabled;
      !oe_level_reg;
   endsequence

   a_shift_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sclk_rise |=> shift_reg[0] == $past(sdat_sync_reg[`LD_SYNC_LAST])) else $error("serial bit not captured");

   a_edge_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_edge_seen |=> !sclk_rise) else $error("one pin edge counted twice");

   a_edge_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_edge_seen |=> sclk_level_reg) else $error("edge level not recorded");

   a_serial_tap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_edge_seen |=> serial_out_o == $past(shift_reg[CHANNELS-2])) else $error("serial output not last stage");

   a_serial_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !sclk_rise |=> $stable(serial_out_o)) else $error("serial output moved without edge");

   a_latch_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_strobe_open |=> latch_reg == $past(shift_reg)) else $error("open latch did not copy");

   a_strobe_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      strb_sync_reg[`LD_SYNC_MID] == strb_sync_reg[`LD_SYNC_LAST]
      |=> strb_level_reg == $past(strb_sync_reg[`LD_SYNC_LAST])) else $error("strobe level not taken");

   a_latch_open_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_strobe_open ##0 s_edge_seen ##1 strb_level_reg |=> latch_reg == $past(shift_reg))
      else $error("latch did not follow shifting");

   a_enable_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      oe_sync_reg[`LD_SYNC_MID] == oe_sync_reg[`LD_SYNC_LAST]
      |=> oe_level_reg == $past(oe_sync_reg[`LD_SYNC_LAST])) else $error("enable level not taken");

   a_disable_shift: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      oe_level_reg && sclk_rise |=> shift_reg[0] == $past(sdat_sync_reg[`LD_SYNC_LAST]))
      else $error("disable stopped shifting");

   a_out_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_drive_enabled ##1 ($stable(latch_reg) && !oe_level_reg) |=> $stable(sink_reg))
      else $error("driver moved with latch steady");

   a_sink_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_drive_enabled ##0 !latch_reg[0] |=> !sink_reg[0]) else $error("sink on for zero");

   a_sink_top: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_drive_enabled ##0 latch_reg[CHANNELS-1] |=> sink_reg[CHANNELS-1]) else $error("last sink not on");

   a_shift_move: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      sclk_rise |=> shift_reg[CHANNELS-1:1] == $past(shift_reg[CHANNELS-2:0])) else $error("shift wrong");

   a_shift_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !sclk_rise |=> $stable(shift_reg)) else $error("shift without edge");

   a_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !strb_level_reg |=> $stable(latch_reg)) else $error("latch changed while closed");

   a_latch_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      s_strobe_open ##1 strb_level_reg |-> latch_reg == $past(shift_reg)) else $error("latch not transparent");

   a_drive_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      oe_level_reg |=> sink_reg == '0) else $error("driver on while disabled");

   a_drive_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !oe_level_reg |=> sink_reg == $past(latch_reg)) else $error("driver not following latch");

   a_disable_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      oe_level_reg && !strb_level_reg && !sclk_rise |=> $stable(latch_reg) && $stable(shift_reg))
      else $error("disable disturbed storage");

   a_sink_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !oe_level_reg && latch_reg[0] |=> sink_reg[0]) else $error("sink not on for one");

endmodule : serial_latched_driver

/* verilog/latched_driver_map.svh */
// timing and width constants for the serial-input latched driver
// assumes inclusion by bare name from the package and design file
`ifndef LATCHED_DRIVER_MAP_SVH
`define LATCHED_DRIVER_MAP_SVH
`define LD_CHANNELS 8
`define LD_CLK_PERIOD_NS 10
`define LD_CLK_TO_STROBE_NS 300
`define LD_STROBE_WIDTH_NS 100
`define LD_SYNC_STAGES 3
`define LD_SYNC_MID 1
`define LD_SYNC_LAST 2
`endif

/* verilog/latched_driver_pkg.sv */
// types for the serial-input latched driver
// assumes the constant header is on the include path
`include "latched_driver_map.svh"
package latched_driver_pkg;
   typedef logic [`LD_CHANNELS-1:0] chan_vec_t;
   typedef logic [`LD_SYNC_STAGES-1:0] sync_vec_t;
endpackage : latched_driver_pkg

/* bench/link_host_model.sv */
// controller model: drives shift clock, serial data and strobe pins
// assumes a 125 ns shift clock that stands still between frames
`timescale 1ns/100ps
module link_host_model (
   // pins toward the driver
   output logic shift_clk_o,
   output logic data_o,
   output logic strobe_o
);
   initial shift_clk_o = 1'b0;
   initial data_o = 1'b0;
   initial strobe_o = 1'b0;
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         data_o <= b[i];
         #31 shift_clk_o <= 1'b1;
         #62.5 shift_clk_o <= 1'b0;
         #31.5;
      end
      // drive the inverse of the last bit, so no stale bit lingers
      data_o <= ~b[0];
   endtask : send
   task automatic pulse();
      #300 strobe_o <= 1'b1;
      #150 strobe_o <= 1'b0;
   endtask : pulse
   task automatic hold_strobe(input logic v);
      strobe_o <= v;
   endtask : hold_strobe
endmodule : link_host_model

/* bench/tb_serial_latched_driver.sv */
// self-checking bench for the serial-input latched driver
// assumes the package is compiled first
`timescale 1ns/100ps
module tb_serial_latched_driver import latched_driver_pkg::*;;
   logic clk_i, rst_n_i, out_disable_i, serial_out_o, shift_clk, serial_in, strobe;
   chan_vec_t sink_on_o;
   int fail_count, n_checks;
   logic [8:0] exp_q[$];
   logic [7:0] a, c;
   event look;
   serial_latched_driver uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .shift_clk_i(shift_clk), .serial_in_i(serial_in),
      .strobe_i(strobe), .out_disable_i(out_disable_i), .serial_out_o(serial_out_o), .sink_on_o(sink_on_o));
   link_host_model host (.shift_clk_o(shift_clk), .data_o(serial_in), .strobe_o(strobe));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] serial_out,sink_on exp %h seen %h", exp, seen);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   // ten cycles covers synchroniser, latch and driver lag
   task automatic expect_out(input logic [8:0] e);
      repeat (10) @(posedge clk_i);
      @(negedge clk_i);
      exp_q.push_back(e);
      ->look;
      @(posedge clk_i);
   endtask : expect_out
   initial forever @(look) check({serial_out_o, sink_on_o}, exp_q.pop_front());
   initial begin
      #500000 fail_count++;
      tally_and_finish();
   end
   // ****
   // main sequence
   // ****
   initial begin
      rst_n_i = 1'b0;
      out_disable_i = 1'b0;
      a = 8'($urandom(32'h2e81));
      repeat (8) @(posedge clk_i);
      rst_n_i <= 1'b1;
      expect_out(9'h000);
      for (int k = 0; k < 4; k++) begin
         a = 8'($urandom);
         host.send(a);
         host.pulse();
         expect_out({a[7], a});
      end
      $display("test load done");
      c = ~a;
      host.send(c);
      expect_out({c[7], a});
      out_disable_i <= 1'b1;
      expect_out({c[7], 8'h00});
      out_disable_i <= 1'b0;
      expect_out({c[7], a});
      $display("test hold and blank done");
      out_disable_i <= 1'b1;
      host.hold_strobe(1'b1);
      c = a ^ 8'h5a;
      host.send(c);
      @(posedge clk_i);
      out_disable_i <= 1'b0;
      expect_out({c[7], c});
      $display("test transparent done");
      tally_and_finish();
   end
endmodule : tb_serial_latched_driver
